// ### verilog/rxsc_map.svh
`ifndef RXSC_MAP_SVH
`define RXSC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices; the byte address is four times the index
`define RXSC_IDX_PAT_HI 10'h05a
`define RXSC_IDX_PAT_LO 10'h05b
`define RXSC_IDX_MODE 10'h05c
`define RXSC_IDX_DEMOD 10'h05d
`define RXSC_IDX_CORR 10'h05e
`define RXSC_IDX_TRIM 10'h05f
`define RXSC_IDX_STAT 10'h060
`define RXSC_ADDR_W 12

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RXSC_RST_PAT_HI 8'h00
`define RXSC_RST_PAT_LO 8'h00
`define RXSC_RST_MODE 8'h00
`define RXSC_RST_DEMOD 8'h00
`define RXSC_RST_CORR 8'h00
`define RXSC_RST_TRIM 8'h00

////////////////////////////////////////////////////////////////////////////////
// writable bits
`define RXSC_WMASK_DEMOD 8'h3f
`define RXSC_WMASK_CORR 8'hf8

////////////////////////////////////////////////////////////////////////////////
// field positions
`define RXSC_MODE_LEN_MSB 7
`define RXSC_MODE_LEN_LSB 4
`define RXSC_MODE_NEG_EDGE 3
`define RXSC_MODE_HALF_LAST 2
`define RXSC_MODE_TYPE_MSB 1
`define RXSC_MODE_TYPE_LSB 0
`define RXSC_DEMOD_AVG 5
`define RXSC_DEMOD_RECT 4
`define RXSC_DEMOD_PEAK 3
`define RXSC_DEMOD_SENSE 2
`define RXSC_DEMOD_FSK 1
`define RXSC_DEMOD_BPSK 0
`define RXSC_CORR_FREQ_MSB 7
`define RXSC_CORR_FREQ_LSB 6
`define RXSC_CORR_RATE_MSB 5
`define RXSC_CORR_RATE_LSB 4
`define RXSC_CORR_SHORT 3
`define RXSC_STAT_BAD_TYPE 0
`define RXSC_STAT_BAD_RATE 1
`define RXSC_STAT_TRIM_TOUCHED 2
`define RXSC_STAT_TRIM_LOADED 3
`define RXSC_STAT_LEN_TYPEB 4

////////////////////////////////////////////////////////////////////////////////
// counts and responses
`define RXSC_WIN_SHORT 7'd32
`define RXSC_WIN_LONG 7'd64
`define RXSC_AVG_SAMPLES 3'd4
`define RXSC_RESP_OKAY 2'b00
`define RXSC_RESP_DECERR 2'b11

`endif

// ### verilog/rxsc_pkg.sv
package rxsc_pkg;

  typedef enum logic [1:0] {
    INTERP_BURST,
    INTERP_PAIR,
    INTERP_BYTE_START,
    INTERP_RESERVED
  } rxsc_interp_e;

  typedef enum logic [1:0] {
    SUB_212K,
    SUB_424K,
    SUB_848K
  } rxsc_subfreq_e;

  typedef enum logic [1:0] {
    RATE_14443,
    RATE_53K_424K,
    RATE_26K_212K,
    RATE_RESERVED
  } rxsc_rate_e;

  typedef struct packed {
    logic [15:0] pattern;
    logic [3:0] valid_bits;
    logic [15:0] compare_mask;
    logic [7:0] exp_data;
    logic [7:0] exp_coll;
    logic grid_from_falling_edge;
    logic half_length_final_bit;
    rxsc_interp_e interp;
  } rxsc_sync_cfg_s;

  typedef struct packed {
    logic four_sample_average;
    logic [2:0] samples_per_value;
    logic rectangular_shaping;
    logic grid_at_correlation_peak;
    logic manchester_sense;
    logic fsk;
    logic bpsk;
  } rxsc_demod_cfg_s;

  typedef struct packed {
    rxsc_subfreq_e subfreq;
    rxsc_rate_e rate;
    logic [6:0] window_len;
  } rxsc_corr_cfg_s;

endpackage : rxsc_pkg

// ### verilog/rxsc_pattern_decode.sv
`timescale 1ns/10ps
`include "rxsc_map.svh"

module rxsc_pattern_decode
  import rxsc_pkg::*;
(
  input wire logic [15:0] pattern,
  input wire logic [3:0] valid_bits,
  input wire rxsc_interp_e interp,
  output logic [15:0] compare_mask,
  output logic [7:0] exp_data,
  output logic [7:0] exp_coll
);

  // the n most significant pattern bits take part; zero bits means none
  function automatic logic [15:0] top_mask(input logic [3:0] n);
    logic [16:0] ones;
    ones = 17'h1ffff << (5'd16 - {1'b0, n});
    top_mask = ones[15:0];
  endfunction : top_mask

  assign compare_mask = top_mask(valid_bits);

  //////////////////////////////////////////////////////////////////////////////
  // each pair is {data, coll}; a set collision flag masks the data bit
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1)
    begin : g_pair
      wire pair_mode = (interp == INTERP_PAIR);
      assign exp_coll[k] = pair_mode & pattern[2*k];
      assign exp_data[k] = pair_mode & pattern[2*k+1] & ~pattern[2*k];
    end
  endgenerate

endmodule : rxsc_pattern_decode

// ### verilog/rxsc_config_regs.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "rxsc_map.svh"

module rxsc_config_regs
  import rxsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] trim_boot_value,
  output rxsc_sync_cfg_s sync_cfg,
  output rxsc_demod_cfg_s demod_cfg,
  output rxsc_corr_cfg_s corr_cfg,
  output logic [7:0] receiver_trim,
  output logic cfg_update
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths

  function automatic logic [6:0] reg_sel(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    reg_sel = 7'h00;
    if (a[1:0] != 2'h0)
      reg_sel = 7'h00;
    else if (idx == `RXSC_IDX_PAT_HI)
      reg_sel = 7'h01;
    else if (idx == `RXSC_IDX_PAT_LO)
      reg_sel = 7'h02;
    else if (idx == `RXSC_IDX_MODE)
      reg_sel = 7'h04;
    else if (idx == `RXSC_IDX_DEMOD)
      reg_sel = 7'h08;
    else if (idx == `RXSC_IDX_CORR)
      reg_sel = 7'h10;
    else if (idx == `RXSC_IDX_TRIM)
      reg_sel = 7'h20;
    else if (idx == `RXSC_IDX_STAT)
      reg_sel = 7'h40;
  endfunction : reg_sel

  function automatic rxsc_subfreq_e freq_of(input logic [1:0] f);
    if (f == 2'h0)
      freq_of = SUB_212K;
    else if (f == 2'h1)
      freq_of = SUB_424K;
    else
      freq_of = SUB_848K;
  endfunction : freq_of

  //////////////////////////////////////////////////////////////////////////////
  // write channel state

  logic aw_full_q;
  logic [11:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // protection bits carry no meaning for this bank
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = ce & aw_full_q & w_full_q & ~bvalid_q;
  wire [6:0] wr_sel = reg_sel(aw_addr_q);
  wire wr_hit = |wr_sel;
  // a write with lane 0 disabled is answered but stores nothing
  wire wr_en = do_write & wr_hit & w_lane0_q;

  assign s_axi_awready = ce & ~aw_full_q & ~bvalid_q & ~unused_prot | ce & ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ce & ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end
    else if (aw_take)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else if (w_take)
    begin
      w_full_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_full_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `RXSC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `RXSC_RESP_OKAY : `RXSC_RESP_DECERR;
    end
    else if (ce && s_axi_bready)
      bvalid_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] pat_hi_q;
  logic [7:0] pat_lo_q;
  logic [7:0] mode_q;
  logic [7:0] demod_q;
  logic [7:0] corr_q;
  logic [7:0] trim_q;
  logic trim_pend_q;
  logic trim_loaded_q;
  logic trim_touched_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pat_hi_q <= `RXSC_RST_PAT_HI;
      pat_lo_q <= `RXSC_RST_PAT_LO;
      mode_q <= `RXSC_RST_MODE;
    end
    else if (wr_en)
    begin
      if (wr_sel[0])
        pat_hi_q <= w_byte_q;
      if (wr_sel[1])
        pat_lo_q <= w_byte_q;
      if (wr_sel[2])
        mode_q <= w_byte_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      demod_q <= `RXSC_RST_DEMOD;
      corr_q <= `RXSC_RST_CORR;
    end
    else if (wr_en)
    begin
      if (wr_sel[3])
        demod_q <= w_byte_q & `RXSC_WMASK_DEMOD;
      if (wr_sel[4])
        corr_q <= w_byte_q & `RXSC_WMASK_CORR;
    end
  end

  // the boot value is caught one enabled cycle after reset release, never
  // inside the reset itself
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_q <= `RXSC_RST_TRIM;
      trim_pend_q <= 1'b1;
      trim_loaded_q <= 1'b0;
    end
    else if (ce && trim_pend_q)
    begin
      trim_q <= trim_boot_value;
      trim_pend_q <= 1'b0;
      trim_loaded_q <= 1'b1;
    end
    else if (wr_en && wr_sel[5])
      trim_q <= w_byte_q;
  end

  // a trim overwrite is remembered so software can see the boot value is gone
  wire stat_clr = wr_en & wr_sel[6] & w_byte_q[`RXSC_STAT_TRIM_TOUCHED];
  wire trim_wr = wr_en & wr_sel[5];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_touched_q <= 1'b0;
    else if (trim_wr)
      trim_touched_q <= 1'b1;
    else if (stat_clr)
      trim_touched_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [3:0] len_f = mode_q[`RXSC_MODE_LEN_MSB:`RXSC_MODE_LEN_LSB];
  wire rxsc_interp_e interp_f = rxsc_interp_e'(mode_q[`RXSC_MODE_TYPE_MSB:`RXSC_MODE_TYPE_LSB]);
  wire [1:0] freq_f = corr_q[`RXSC_CORR_FREQ_MSB:`RXSC_CORR_FREQ_LSB];
  wire rxsc_rate_e rate_f = rxsc_rate_e'(corr_q[`RXSC_CORR_RATE_MSB:`RXSC_CORR_RATE_LSB]);
  wire avg_f = demod_q[`RXSC_DEMOD_AVG];

  wire bad_type = (interp_f == INTERP_RESERVED);
  wire bad_rate = (rate_f == RATE_RESERVED);
  wire len_typeb = (interp_f == INTERP_BYTE_START) & (len_f != 4'h0);

  wire [15:0] pattern_w = {pat_hi_q, pat_lo_q};
  wire [15:0] mask_w;
  wire [7:0] exp_data_w;
  wire [7:0] exp_coll_w;

  rxsc_pattern_decode u_pattern_decode (
    .pattern(pattern_w),
    .valid_bits(len_f),
    .interp(interp_f),
    .compare_mask(mask_w),
    .exp_data(exp_data_w),
    .exp_coll(exp_coll_w)
  );

  rxsc_sync_cfg_s sync_d;
  rxsc_demod_cfg_s demod_d;
  rxsc_corr_cfg_s corr_d;

  assign sync_d.pattern = pattern_w;
  assign sync_d.valid_bits = len_f;
  assign sync_d.compare_mask = mask_w;
  assign sync_d.exp_data = exp_data_w;
  assign sync_d.exp_coll = exp_coll_w;
  assign sync_d.grid_from_falling_edge = mode_q[`RXSC_MODE_NEG_EDGE];
  assign sync_d.half_length_final_bit = mode_q[`RXSC_MODE_HALF_LAST];
  assign sync_d.interp = interp_f;

  assign demod_d.four_sample_average = avg_f;
  assign demod_d.samples_per_value = avg_f ? `RXSC_AVG_SAMPLES : 3'd1;
  assign demod_d.rectangular_shaping = demod_q[`RXSC_DEMOD_RECT];
  assign demod_d.grid_at_correlation_peak = demod_q[`RXSC_DEMOD_PEAK];
  assign demod_d.manchester_sense = demod_q[`RXSC_DEMOD_SENSE];
  assign demod_d.fsk = demod_q[`RXSC_DEMOD_FSK];
  assign demod_d.bpsk = demod_q[`RXSC_DEMOD_BPSK];

  assign corr_d.subfreq = freq_of(freq_f);
  assign corr_d.rate = rate_f;
  assign corr_d.window_len = corr_q[`RXSC_CORR_SHORT] ? `RXSC_WIN_SHORT : `RXSC_WIN_LONG;

  //////////////////////////////////////////////////////////////////////////////
  // registered configuration towards the datapath

  rxsc_sync_cfg_s sync_q;
  rxsc_demod_cfg_s demod_cfg_q;
  rxsc_corr_cfg_s corr_cfg_q;
  logic [7:0] trim_out_q;
  logic upd_pend_q;
  logic cfg_update_q;

  // outputs trail the registers by one cycle; the update pulse is aligned
  // with the cycle in which the new values first show
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_q <= '0;
      demod_cfg_q <= '0;
      corr_cfg_q <= '0;
      trim_out_q <= `RXSC_RST_TRIM;
    end
    else if (ce)
    begin
      sync_q <= sync_d;
      demod_cfg_q <= demod_d;
      corr_cfg_q <= corr_d;
      trim_out_q <= trim_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upd_pend_q <= 1'b0;
      cfg_update_q <= 1'b0;
    end
    else if (ce)
    begin
      upd_pend_q <= wr_en & ~wr_sel[6];
      cfg_update_q <= upd_pend_q;
    end
  end

  assign sync_cfg = sync_q;
  assign demod_cfg = demod_cfg_q;
  assign corr_cfg = corr_cfg_q;
  assign receiver_trim = trim_out_q;
  assign cfg_update = cfg_update_q;

  //////////////////////////////////////////////////////////////////////////////
  // read channel

  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rdata_q;

  wire [6:0] rd_sel = reg_sel(s_axi_araddr);
  wire ar_take = s_axi_arvalid & s_axi_arready;

  wire [7:0] stat_w = {3'h0, len_typeb, trim_loaded_q, trim_touched_q, bad_rate, bad_type};

  wire [7:0] rd_value = rd_sel[0] ? pat_hi_q :
                        rd_sel[1] ? pat_lo_q :
                        rd_sel[2] ? mode_q :
                        rd_sel[3] ? demod_q :
                        rd_sel[4] ? corr_q :
                        rd_sel[5] ? trim_q :
                        rd_sel[6] ? stat_w : 8'h00;

  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rdata_q};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `RXSC_RESP_OKAY;
      rdata_q <= 8'h00;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= (|rd_sel) ? `RXSC_RESP_OKAY : `RXSC_RESP_DECERR;
      rdata_q <= rd_value;
    end
    else if (ce && s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule : rxsc_config_regs

// ### test/rxsc_config_regs_properties.sv
`timescale 1ns/10ps

module rxsc_config_regs_properties
  import rxsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rxsc_sync_cfg_s sync_cfg,
  input wire rxsc_demod_cfg_s demod_cfg,
  input wire rxsc_corr_cfg_s corr_cfg,
  input wire logic cfg_update
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a length of zero shifts every bit out, so nothing may be compared
  logic [15:0] len_mask;
  assign len_mask = 16'hffff << (5'd16 - {1'b0, sync_cfg.valid_bits});

  ////////////////////////////////////////////////////////////////////////////////
  write_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) ##1 ce [*2] |-> s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) ##1 ce |-> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !(s_axi_bready && ce)
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !(s_axi_rready && ce)
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  busy_refuse_a: assert property ((s_axi_bvalid -> !s_axi_awready && !s_axi_wready)
    && (s_axi_rvalid -> !s_axi_arready)) else $error("request taken while busy");
  ce_freeze_a: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
    else $error("ready while disabled");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  pair_only_a: assert property (sync_cfg.interp != INTERP_PAIR |->
    sync_cfg.exp_coll == 8'h00 && sync_cfg.exp_data == 8'h00) else $error("pair decode leak");
  coll_masks_a: assert property ((sync_cfg.exp_data & sync_cfg.exp_coll) == 8'h00)
    else $error("collision does not mask data");
  mask_len_a: assert property ((sync_cfg.compare_mask & ~len_mask) == 16'h0000)
    else $error("compare mask beyond length");
  avg_count_a: assert property (demod_cfg.samples_per_value != 3'd0 |->
    demod_cfg.samples_per_value == (demod_cfg.four_sample_average ? 3'd4 : 3'd1))
    else $error("sample count wrong");
  window_len_a: assert property (corr_cfg.window_len != 7'd0 |->
    corr_cfg.window_len inside {7'd32, 7'd64}) else $error("window length wrong");
  freq_code_a: assert property (corr_cfg.subfreq != 2'b11)
    else $error("subcarrier code out of range");
  update_pulse_a: assert property (cfg_update |=> !cfg_update) else $error("update not a pulse");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && !$past(ce));
  cover property (sync_cfg.interp == INTERP_PAIR && sync_cfg.exp_coll != 8'h00);
  cover property (cfg_update);
endmodule : rxsc_config_regs_properties

bind rxsc_config_regs rxsc_config_regs_properties u_props (.aclk, .aresetn, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .sync_cfg, .demod_cfg, .corr_cfg, .cfg_update);

// ### test/rxsc_config_regs_tb.sv
`timescale 1ns/10ps
`include "rxsc_map.svh"

module rxsc_config_regs_tb
  import rxsc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [7:0] trim_boot_value = 8'ha5;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_update;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] receiver_trim;
  rxsc_sync_cfg_s sync_cfg;
  rxsc_demod_cfg_s demod_cfg;
  rxsc_corr_cfg_s corr_cfg;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] mdl [0:5];
  logic [15:0] rnd = 16'h0020;
  logic trim_set = 1'b0;
  int upd_seen = 0;
  int upd_exp = 0;

  rxsc_config_regs dut (.*);

  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // the whole run is a few hundred cycles, so this only catches a hang
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cfg_update === 1'b1)
      upd_seen <= upd_seen + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] next_rnd();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[7:0];
  endfunction : next_rnd

  function automatic logic [7:0] wmask(input int i);
    return i == 3 ? `RXSC_WMASK_DEMOD : (i == 4 ? `RXSC_WMASK_CORR : 8'hff);
  endfunction : wmask

  // status as the bank reports it; the boot trim is always loaded by the time it is read
  function automatic logic [7:0] stat_exp();
    return {3'h0, mdl[2][1:0] == 2'd2 && mdl[2][7:4] != 4'h0, 1'b1, trim_set,
      mdl[4][5:4] == 2'd3, mdl[2][1:0] == 2'd3};
  endfunction : stat_exp

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  task wr(input logic [11:0] a, input logic [7:0] d, input logic s);
    logic ok;
    int i;
    i = int'(a >> 2) - 'h5a;
    ok = a[1:0] == 2'b00 && a >= 12'h168 && a <= 12'h180;
    if (ok && s && i < 6)
    begin
      mdl[i] = d & wmask(i);
      upd_exp++;
    end
    if (ok && s && i == 5)
      trim_set = 1'b1;
    if (ok && s && i == 6 && d[2])
      trim_set = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {next_rnd(), 16'h0000, d};
    s_axi_wstrb <= {3'b111, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && ce));
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, ok ? `RXSC_RESP_OKAY : `RXSC_RESP_DECERR);
  endtask : wr

  task rd(input logic [11:0] a);
    logic ok;
    int i;
    i = int'(a >> 2) - 'h5a;
    ok = a[1:0] == 2'b00 && a >= 12'h168 && a <= 12'h180;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && ce));
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, ok ? `RXSC_RESP_OKAY : `RXSC_RESP_DECERR);
    if (ok)
      chk("rdata", s_axi_rdata, {24'h000000, i == 6 ? stat_exp() : mdl[i]});
  endtask : rd

  task rd_all();
    for (int a = 'h168; a <= 'h180; a += 4)
      rd(12'(a));
  endtask : rd_all

  task chk_outs();
    logic [15:0] p, msk;
    logic [7:0] ed, ec, m, dm, c;
    p = {mdl[0], mdl[1]};
    m = mdl[2];
    dm = mdl[3];
    c = mdl[4];
    msk = ~(16'hffff >> m[7:4]);
    for (int k = 0; k < 8; k++)
    begin
      ec[k] = m[1:0] == 2'd1 && p[2*k];
      ed[k] = m[1:0] == 2'd1 && p[2*k+1] && !p[2*k];
    end
    chk("pattern", sync_cfg.pattern, p);
    chk("mode", {sync_cfg.valid_bits, sync_cfg.grid_from_falling_edge,
      sync_cfg.half_length_final_bit, sync_cfg.interp}, m);
    chk("pairs", {sync_cfg.exp_data, sync_cfg.exp_coll}, {ed, ec});
    chk("mask", sync_cfg.compare_mask, msk);
    chk("demod", {demod_cfg.four_sample_average, demod_cfg.rectangular_shaping,
      demod_cfg.grid_at_correlation_peak, demod_cfg.manchester_sense,
      demod_cfg.fsk, demod_cfg.bpsk}, dm[5:0]);
    chk("samples", demod_cfg.samples_per_value, dm[5] ? 32'd4 : 32'd1);
    chk("corr", {corr_cfg.subfreq, corr_cfg.rate}, {c[7] ? 2'd2 : c[7:6], c[5:4]});
    chk("window", corr_cfg.window_len, c[3] ? 32'd32 : 32'd64);
    chk("trim", receiver_trim, mdl[5]);
  endtask : chk_outs

  task settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk_outs();
    rd_all();
    // every interpretation, frequency and rate code, with the reserved demod bits written as ones
    for (int t = 0; t < 4; t++)
    begin
      wr(12'h168, next_rnd(), 1'b1);
      wr(12'h16c, next_rnd(), 1'b1);
      wr(12'h170, (next_rnd() & 8'hfc) | 8'(t), 1'b1);
      wr(12'h174, 8'hc0 | next_rnd(), 1'b1);
      wr(12'h178, 8'(t * 'h50) | (next_rnd() & 8'h0f), 1'b1);
      settle();
      chk_outs();
      rd_all();
    end
    wr(12'h168, 8'h77, 1'b0);
    wr(12'h184, 8'h11, 1'b1);
    wr(12'h16d, 8'h22, 1'b1);
    rd(12'h184);
    rd(12'h169);
    wr(12'h17c, 8'h5a, 1'b1);
    settle();
    chk_outs();
    rd(12'h168);
    rd(12'h180);
    wr(12'h180, 8'h04, 1'b1);
    rd(12'h180);
    @(posedge aclk);
    ce <= 1'b0;
    fork
      rd(12'h170);
      begin
        repeat (6) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    @(posedge aclk);
    aresetn <= 1'b0;
    trim_boot_value <= 8'h3c;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c};
    trim_set = 1'b0;
    settle();
    chk_outs();
    rd_all();
    chk("updates", upd_seen, upd_exp);
    complete_run();
  end
endmodule : rxsc_config_regs_tb
